//--- hw/anpg_pkg.sv
package anpg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the serial management frame
  localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_NEG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_NEXT_PAGE_TX = 5'h07;
  localparam logic [4:0] REG_PARTNER_NEXT_PAGE_RX = 5'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Partner ability field positions
  localparam int PA_NEXT_PAGE = 15;
  localparam int PA_ACK = 14;
  localparam int PA_RFAULT = 13;
  localparam int PA_ASYM_PAUSE = 11;
  localparam int PA_PAUSE = 10;
  localparam int PA_ABIL_HI = 9;
  localparam int PA_ABIL_LO = 5;
  localparam int PA_SEL_HI = 4;
  localparam int PA_SEL_LO = 0;
  localparam logic [15:0] PA_RESET = 16'h0000;

  // Expansion field positions
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_PARTNER_AN = 0;
  localparam logic EXP_LOCAL_NP_VAL = 1'b1;

  // Next page reset values and writable bits
  localparam logic [15:0] NPT_RESET = 16'h2001;
  localparam logic [15:0] NPR_RESET = 16'h0000;
  localparam logic [15:0] NPT_WR_MASK = 16'hf7ff;
  localparam logic TOGGLE_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Management frame timing, in management clock bits
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0b;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic morePages;
    logic bit14;
    logic msgPage;
    logic secondAck;
    logic toggle;
    logic [10:0] code;
  } anpg_page_t;

  typedef struct packed {
    logic restart;
    logic baseRx;
    logic nextRx;
    logic pdFault;
    logic pageSent;
  } anpg_anev_t;

  typedef enum logic [2:0] {sIdle, sStart, sHdr, sTa, sData} anpg_mdio_st_t;

endpackage : anpg_pkg

//--- hw/anpg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module anpg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Change accepted only when stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : anpg_sync
`default_nettype wire

//--- hw/anpg_regs.sv
// Functional notes
// - Partner next-page bit reports partner wants to send next pages.
// - Partner acknowledge bit set once partner code word received successfully.
// - Partner remote fault copied as received; no action taken on it.
// - Partner selector field shown; cleared on negotiation restart or reset.
// - Five partner ability bits shown; cleared on negotiation restart or reset.
// - Partner pause bit mirrors pause bit in received ability word.
// - Parallel detection fault latched high; cleared by expansion read or reset.
// - Partner next-page-able flag always equals partner ability bit 15.
// - Local next-page-able flag is constant one, read-only.
// - Page received flag latched on checked page; held until reset.
// - Partner negotiation-able flag set only once partner known capable.
// - Message-page bit selects formatted page when one; resets to one.
// - Transmit toggle read-only, inverse of previously sent toggle.
// - Eleven-bit code field carries message or unformatted value.
// - Received next page fields read-only, all reset to zero.
// - Received toggle bit is inverse of partner's previous toggle.
// - Received second acknowledge reports partner compliance.
`timescale 1ns/1ps
`default_nettype none
module anpg_regs
  import anpg_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOeN,
  input wire anpg_pkg::anpg_anev_t anEv,
  input wire logic [15:0] rxWord,
  output anpg_pkg::anpg_page_t nextTxWord,
  output logic nextTxLoaded,
  output logic partnerAnAble
);
  import anpg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic mdcF;
  logic mdioF;
  logic mdcPrev_r;
  logic mdcRise;
  logic bitIn;

  anpg_sync #(
    .WIDTH(2),
    .RST_VAL(2'h3)
  ) uSync (
    .mclk(mclk),
    .nrst(nrst),
    .din({mdc, mdioIn}),
    .dout({mdcF, mdioF})
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mdcPrev_r <= 1'b1;
    end else begin
      mdcPrev_r <= mdcF;
    end
  end

  // Pins reset to one, so leaving reset makes no false mdc edge
  // Host drives data ahead of the rising edge, so sample there
  assign mdcRise = mdcF & ~mdcPrev_r;
  assign bitIn = mdioF;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] partnerAbility_r;
  logic pdFault_r;
  logic pageRx_r;
  logic partnerAn_r;
  anpg_page_t npt_r;
  anpg_page_t npr_r;
  logic [15:0] expansion;

  ////////////////////////////////////////////////////////////////////////////
  // Management frame decode
  anpg_mdio_st_t state_r;
  logic [4:0] cnt_r;
  logic [5:0] ones_r;
  logic [10:0] hdr_r;
  logic readOp_r;
  logic hit_r;
  logic [4:0] regAddr_r;
  logic [14:0] wrShift_r;
  logic [11:0] hdrFull;
  logic hdrDone;
  logic hdrHit;
  logic rdEn;
  logic wrEn;
  logic [15:0] wrData;
  logic [1:0] hdrOp;
  logic [4:0] hdrPhy;
  logic [4:0] hdrReg;
  logic opKnown;
  logic expRead;
  logic nptWrite;

  // Header: op, phy address, register; last bit still on the pin
  assign hdrFull = {hdr_r, bitIn};
  assign hdrOp = hdrFull[11:10];
  assign hdrPhy = hdrFull[9:5];
  assign hdrReg = hdrFull[4:0];
  assign opKnown = (hdrOp == OP_READ) || (hdrOp == OP_WRITE);
  assign hdrDone = mdcRise && (state_r == sHdr) && (cnt_r == HDR_LAST);
  assign hdrHit = (hdrPhy == PHY_ADDR);
  assign rdEn = hdrDone && hdrHit && (hdrOp == OP_READ);
  assign wrEn = mdcRise && (state_r == sData) && (cnt_r == DATA_LAST) && hit_r && !readOp_r;
  assign wrData = {wrShift_r, bitIn};
  // Strobes for the two registers with side effects
  assign expRead = rdEn && (hdrReg == REG_NEG_EXPANSION);
  assign nptWrite = wrEn && (regAddr_r == REG_NEXT_PAGE_TX);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= sIdle;
      cnt_r <= 5'h00;
      ones_r <= 6'h00;
      hdr_r <= 11'h000;
      readOp_r <= 1'b0;
      hit_r <= 1'b0;
      regAddr_r <= 5'h00;
      wrShift_r <= 15'h0000;
    end else if (mdcRise) begin
      unique case (state_r)
        sIdle: begin
          // Count saturates, so a long idle line still qualifies
          if (bitIn) begin
            if (ones_r != PREAMBLE_LEN) begin
              ones_r <= ones_r + 6'h01;
            end
          end else if (ones_r == PREAMBLE_LEN) begin
            state_r <= sStart;
          end else begin
            ones_r <= 6'h00;
          end
        end
        sStart: begin
          ones_r <= 6'h00;
          cnt_r <= 5'h00;
          state_r <= bitIn ? sHdr : sIdle;
        end
        sHdr: begin
          hdr_r <= hdrFull[10:0];
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == HDR_LAST) begin
            readOp_r <= (hdrOp == OP_READ);
            // Ops 00 and 11 run to the end without touching the pin
            hit_r <= hdrHit && opKnown;
            regAddr_r <= hdrReg;
            cnt_r <= 5'h00;
            state_r <= sTa;
          end
        end
        sTa: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r != 5'h00) begin
            cnt_r <= 5'h00;
            state_r <= sData;
          end
        end
        sData: begin
          wrShift_r <= wrData[14:0];
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == DATA_LAST) begin
            cnt_r <= 5'h00;
            state_r <= sIdle;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: turnaround zero, then sixteen data bits, msb first
  logic [15:0] rdMux;
  logic [15:0] rdShift_r;

  always_comb begin
    rdMux = 16'h0000;
    unique case (hdrReg)
      REG_PARTNER_ABILITY: rdMux = partnerAbility_r;
      REG_NEG_EXPANSION: rdMux = expansion;
      REG_NEXT_PAGE_TX: rdMux = npt_r;
      REG_PARTNER_NEXT_PAGE_RX: rdMux = npr_r;
      default: rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdShift_r <= 16'h0000;
      mdioOut <= 1'b1;
      mdioOeN <= 1'b1;
    end else if (mdcRise) begin
      if (rdEn) begin
        // Snapshot at decode so a later event cannot tear the word
        rdShift_r <= rdMux;
      end
      if (state_r == sTa && readOp_r && hit_r) begin
        if (cnt_r == 5'h00) begin
          mdioOut <= 1'b0;
          mdioOeN <= 1'b0;
        end else begin
          mdioOut <= rdShift_r[15];
          rdShift_r <= {rdShift_r[14:0], 1'b0};
        end
      end else if (state_r == sData && readOp_r && hit_r && cnt_r != DATA_LAST) begin
        mdioOut <= rdShift_r[15];
        rdShift_r <= {rdShift_r[14:0], 1'b0};
      end else begin
        mdioOut <= 1'b1;
        mdioOeN <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partner ability
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      partnerAbility_r <= PA_RESET;
    end else if (anEv.restart) begin
      // Restart beats a page arriving in the same cycle
      partnerAbility_r <= PA_RESET;
    end else if (anEv.baseRx) begin
      partnerAbility_r[PA_NEXT_PAGE] <= rxWord[PA_NEXT_PAGE];
      partnerAbility_r[PA_ACK] <= 1'b1;
      partnerAbility_r[PA_RFAULT] <= rxWord[PA_RFAULT];
      partnerAbility_r[PA_ASYM_PAUSE] <= rxWord[PA_ASYM_PAUSE];
      partnerAbility_r[PA_PAUSE] <= rxWord[PA_PAUSE];
      partnerAbility_r[PA_ABIL_HI:PA_ABIL_LO] <= rxWord[PA_ABIL_HI:PA_ABIL_LO];
      partnerAbility_r[PA_SEL_HI:PA_SEL_LO] <= rxWord[PA_SEL_HI:PA_SEL_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expansion flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pdFault_r <= 1'b0;
    end else if (anEv.pdFault) begin
      // New fault wins over the clearing read
      pdFault_r <= 1'b1;
    end else if (expRead) begin
      pdFault_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pageRx_r <= 1'b0;
    end else if (anEv.baseRx || anEv.nextRx) begin
      // Restart leaves it set; only chip reset drops it
      pageRx_r <= 1'b1;
    end
  end

  // Only a checked base page proves the partner negotiates
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      partnerAn_r <= 1'b0;
    end else if (anEv.baseRx) begin
      partnerAn_r <= 1'b1;
    end else if (anEv.restart) begin
      partnerAn_r <= 1'b0;
    end
  end

  always_comb begin
    // Bits 15:5 read back as zero
    expansion = 16'h0000;
    expansion[EXP_PD_FAULT] = pdFault_r;
    expansion[EXP_PARTNER_NP] = partnerAbility_r[PA_NEXT_PAGE];
    expansion[EXP_LOCAL_NP] = EXP_LOCAL_NP_VAL;
    expansion[EXP_PAGE_RX] = pageRx_r;
    expansion[EXP_PARTNER_AN] = partnerAn_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local next page: host fields plus hardware toggle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      npt_r <= NPT_RESET;
    end else begin
      if (nptWrite) begin
        // Host owns more-pages, bit 14, message, second ack and code
        npt_r <= (wrData & NPT_WR_MASK) | (npt_r & ~NPT_WR_MASK);
      end
      // A same-cycle write keeps the hardware toggle
      if (anEv.restart) begin
        npt_r.toggle <= TOGGLE_RESET;
      end else if (anEv.pageSent) begin
        npt_r.toggle <= ~npt_r.toggle;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      nextTxWord <= NPT_RESET;
      nextTxLoaded <= 1'b0;
      partnerAnAble <= 1'b0;
    end else begin
      nextTxWord <= npt_r;
      nextTxLoaded <= nptWrite;
      partnerAnAble <= partnerAn_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partner next page, read-only image of the last checked page
  localparam int NP_MORE_POS = 15;
  localparam int NP_ACK_POS = 14;
  localparam int NP_MSG_POS = 13;
  localparam int NP_SECOND_ACKNOWLEDGE_POS = 12;
  localparam int NP_TOGGLE_POS = 11;
  localparam int NP_CODE_HI = 10;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      npr_r <= NPR_RESET;
    end else if (anEv.nextRx) begin
      npr_r.morePages <= rxWord[NP_MORE_POS];
      npr_r.bit14 <= rxWord[NP_ACK_POS];
      npr_r.msgPage <= rxWord[NP_MSG_POS];
      npr_r.secondAck <= rxWord[NP_SECOND_ACKNOWLEDGE_POS];
      // Stored inverted: reads as the toggle the partner sends next
      npr_r.toggle <= ~rxWord[NP_TOGGLE_POS];
      npr_r.code <= rxWord[NP_CODE_HI:0];
    end
  end

endmodule : anpg_regs
`default_nettype wire

//--- verif/anpg_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module anpg_partner_model (
  input wire logic mclk,
  output anpg_pkg::anpg_anev_t anEv,
  output logic [15:0] rxWord
);
  import anpg_pkg::*;

  initial begin
    anEv = '0;
    rxWord = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle event; word is valid only with the pulse, inverted after
  task automatic send(input anpg_anev_t ev, input logic [15:0] w);
    @(negedge mclk);
    anEv = ev;
    rxWord = w;
    @(negedge mclk);
    anEv = '0;
    rxWord = ~w;
  endtask : send
endmodule : anpg_partner_model
`default_nettype wire

//--- verif/anpg_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module anpg_regs_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOeN,
  input wire anpg_pkg::anpg_anev_t anEv,
  input wire logic [15:0] rxWord,
  input wire anpg_pkg::anpg_page_t nextTxWord,
  input wire logic nextTxLoaded,
  input wire logic partnerAnAble
);
  import anpg_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  a_base_sets_able: assert property (anEv.baseRx |-> ##2 partnerAnAble)
    else $error("able flag missed base page");
  a_restart_clr_able: assert property (anEv.restart && !anEv.baseRx |-> ##2 !partnerAnAble)
    else $error("able flag kept over restart");
  a_able_holds: assert property (!anEv.restart && !anEv.baseRx |-> ##2 $stable(partnerAnAble))
    else $error("able flag moved without cause");
  a_load_one_cycle: assert property (nextTxLoaded |=> !nextTxLoaded)
    else $error("load pulse too long");
  // Two cycles: register, then the registered page copy
  a_toggle_flips: assert property (anEv.pageSent && !anEv.restart |->
    ##2 nextTxWord.toggle != $past(nextTxWord.toggle, 2))
    else $error("toggle did not invert");
  a_restart_tog_zero: assert property (anEv.restart |-> ##2 !nextTxWord.toggle)
    else $error("toggle not cleared by restart");
  a_word_cause: assert property ($changed(nextTxWord) |-> nextTxLoaded ||
    $past(nextTxLoaded) || $past(nextTxLoaded, 2) || $past(anEv.pageSent, 2) ||
    $past(anEv.restart, 2))
    else $error("page word changed without cause");
  a_idle_high: assert property (mdioOeN |-> mdioOut)
    else $error("released data not high");
  a_ta_drive_zero: assert property ($fell(mdioOeN) |-> !mdioOut && $past(mdc, 2))
    else $error("turnaround drive wrong");
endmodule : anpg_regs_monitor

bind anpg_regs anpg_regs_monitor mon (.mclk(mclk), .nrst(nrst), .mdc(mdc), .mdioIn(mdioIn),
  .mdioOut(mdioOut), .mdioOeN(mdioOeN), .anEv(anEv), .rxWord(rxWord),
  .nextTxWord(nextTxWord), .nextTxLoaded(nextTxLoaded), .partnerAnAble(partnerAnAble));
`default_nettype wire

//--- verif/anpg_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module anpg_regs_tb_top;
  import anpg_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic mdc = 1'b0;
  logic hostBit = 1'b1;
  logic hostOe = 1'b1;
  logic mdioOut, mdioOeN, nextTxLoaded, partnerAnAble;
  logic [15:0] rxWord;
  anpg_anev_t anEv;
  anpg_page_t nextTxWord;
  wire logic mdioPin;
  int errorCnt = 0;
  int checks = 0;
  int cyc = 0;
  int loads = 0;

  // Pull-up on the shared data line when nobody drives
  assign mdioPin = !mdioOeN ? mdioOut : (hostOe ? hostBit : 1'b1);
  always #20 mclk = ~mclk;

  // Load pulse counted off the launching edge
  always @(negedge mclk) begin
    if (nextTxLoaded === 1'b1) begin
      loads++;
    end
  end

  anpg_regs uut (.mclk(mclk), .nrst(nrst), .mdc(mdc), .mdioIn(mdioPin), .mdioOut(mdioOut),
    .mdioOeN(mdioOeN), .anEv(anEv), .rxWord(rxWord), .nextTxWord(nextTxWord),
    .nextTxLoaded(nextTxLoaded), .partnerAnAble(partnerAnAble));
  anpg_partner_model partner (.mclk(mclk), .anEv(anEv), .rxWord(rxWord));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finishTest

  // About 22 frames of 650 cycles are expected
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errorCnt++;
      finishTest();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Slow management clock: the pins pass a three-flop synchroniser
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, PHY_ADDR_DEFAULT, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(negedge mclk);
      mdc = 1'b0;
      hostBit = f[63-i];
      hostOe = !(op == OP_READ && i >= 46);
      repeat (5) @(negedge mclk);
      if (i >= 48) rd = {rd[14:0], mdioPin};
      mdc = 1'b1;
      repeat (4) @(negedge mclk);
    end
    @(negedge mclk);
    mdc = 1'b0;
    hostOe = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : frame

  task automatic rdChk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] r;
    frame(OP_READ, ra, 16'h0000, r);
    chk(r, exp);
  endtask : rdChk

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] r;
    frame(OP_WRITE, ra, d, r);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    rdChk(5'h05, 16'h0000);
    rdChk(5'h06, 16'h0004);
    rdChk(5'h07, 16'h2001);
    rdChk(5'h08, 16'h0000);
    chk(nextTxWord, 16'h2001);
    rdChk(5'h1f, 16'h0000);
    wr(5'h05, 16'hffff);
    chk(loads[15:0], 16'h0000);
    rdChk(5'h05, 16'h0000);
    $display("test reset done");
  endtask : testReset

  task automatic testBase();
    partner.send(5'b01000, 16'hafe1);
    rdChk(5'h05, 16'hefe1);
    rdChk(5'h06, 16'h000f);
    chk({15'h0000, partnerAnAble}, 16'h0001);
    partner.send(5'b01000, 16'h0422);
    rdChk(5'h05, 16'h4422);
    rdChk(5'h06, 16'h0007);
    $display("test base done");
  endtask : testBase

  task automatic testFault();
    partner.send(5'b00010, 16'h0000);
    rdChk(5'h06, 16'h0017);
    rdChk(5'h06, 16'h0007);
    $display("test fault done");
  endtask : testFault

  task automatic testPages();
    partner.send(5'b00100, 16'h9a55);
    rdChk(5'h08, 16'h9255);
    wr(5'h07, 16'hffff);
    chk(loads[15:0], 16'h0001);
    rdChk(5'h07, 16'hf7ff);
    chk(nextTxWord, 16'hf7ff);
    partner.send(5'b00001, 16'h0000);
    rdChk(5'h07, 16'hffff);
    wr(5'h07, 16'h0000);
    chk(loads[15:0], 16'h0002);
    rdChk(5'h07, 16'h0800);
    $display("test pages done");
  endtask : testPages

  task automatic testRestart();
    partner.send(5'b10000, 16'h0000);
    rdChk(5'h05, 16'h0000);
    rdChk(5'h06, 16'h0006);
    rdChk(5'h07, 16'h0000);
    $display("test restart done");
  endtask : testRestart

  initial begin
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    testReset();
    testBase();
    testFault();
    testPages();
    testRestart();
    finishTest();
  end
endmodule : anpg_regs_tb_top
`default_nettype wire
